// ### inc/ulsmc_consts.svh
`ifndef ULSMC_CONSTS_SVH
`define ULSMC_CONSTS_SVH
// host register addresses
`define ULSMC_ADDR_RHR 3'h0
`define ULSMC_ADDR_MCR 3'h4
`define ULSMC_ADDR_LSR 3'h5
// line status fields
`define ULSMC_LSR_DR 0
`define ULSMC_LSR_OE 1
`define ULSMC_LSR_PE 2
`define ULSMC_LSR_FE 3
`define ULSMC_LSR_BI 4
`define ULSMC_LSR_THRE 5
`define ULSMC_LSR_TEMT 6
`define ULSMC_LSR_FERR 7
// modem control fields
`define ULSMC_MCR_DTR 0
`define ULSMC_MCR_RTS 1
`define ULSMC_MCR_RDY 2
`define ULSMC_MCR_IRQ 3
`define ULSMC_MCR_LOOP 4
`define ULSMC_MCR_XANY 5
`define ULSMC_MCR_TACC 6
`define ULSMC_MCR_CLK 7
`define ULSMC_MCR_RST 8'h00
// prescaler and buffering
`define ULSMC_PRESC_LAST 2'h3
`define ULSMC_FIFO_DEPTH 8
`define ULSMC_CHAR_W 8
`endif

// ### inc/ulsmc_pkg.sv
package ulsmc_pkg;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulsmc_rx_entry_t;

  typedef struct packed {
    logic [7:0] modem_control;
    logic [7:0] rdata;
    logic [3:0] err_cnt;
    logic ovr;
    logic ser_out;
    logic ser_in;
    logic rts_n;
    logic dtr_n;
    logic irq_a;
    logic irq_b;
    logic irq_oe;
    logic gop;
    logic [3:0] msr_hi;
    logic xon_any;
    logic thr_acc;
    logic rdy_en;
  } ulsmc_state_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } ulsmc_presc_t;

endpackage : ulsmc_pkg

// ### verilog/ulsmc_fifo.sv
`timescale 1ns/1ps
module ulsmc_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic full;
    logic empty;
  } ulsmc_fifo_st_t;

  ulsmc_fifo_st_t st_q, st_d;
  logic wr, rd;

  assign wr = in_valid_i && !st_q.full;
  assign rd = out_ready_i && !st_q.empty;
  assign in_ready_o = !st_q.full;
  assign out_valid_o = !st_q.empty;
  assign out_data_o = st_q.mem[st_q.rp];

  always_comb begin
    st_d = st_q;
    if (wr) begin
      st_d.mem[st_q.wp] = in_data_i;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (rd) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    // simultaneous push and pop keep the count
    st_d.cnt = st_q.cnt + {{PW{1'b0}}, wr} - {{PW{1'b0}}, rd};
    st_d.full = (st_d.cnt == (PW+1)'(DEPTH));
    st_d.empty = (st_d.cnt == '0);
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '{default: '0, empty: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
endmodule : ulsmc_fifo

// ### verilog/ulsmc_presc.sv
`timescale 1ns/1ps
`include "ulsmc_consts.svh"
module ulsmc_presc (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // divide select and enable out
  input wire logic div4_i,
  output logic tick_o
);
  ulsmc_pkg::ulsmc_presc_t st_q, st_d;

  assign tick_o = st_q.tick;

  always_comb begin
    st_d = st_q;
    if (div4_i) begin
      st_d.cnt = st_q.cnt + 2'h1;
      st_d.tick = (st_q.cnt == `ULSMC_PRESC_LAST);
    end else begin
      st_d.cnt = 2'h0;
      st_d.tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  sequence quiet_three;
    !tick_o [*3];
  endsequence

  div4_gap_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (div4_i && tick_o) |=> !tick_o)
    else $error("prescaler tick spacing wrong");
  div4_seq_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (div4_i [*3] ##1 (div4_i && tick_o)) |=>
      quiet_three or (##[0:2] !div4_i))
    else $error("tick came early under divide by four");
  div1_run_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (!div4_i [*2]) |-> tick_o)
    else $error("tick missing under divide by one");
endmodule : ulsmc_presc

// ### verilog/ulsmc_top.sv
`timescale 1ns/1ps
`include "ulsmc_consts.svh"
// What this block does
// - fifo error bit tracks any flagged entry
// - transmit empty needs holding and shift empty
// - holding empty bit mirrors holding register
// - break character is stored as 00
// - framing bit comes from top entry
// - parity bit comes from top entry
// - overrun bit set when data lost
// - data ready while receive fifo nonempty
// - top flags read directly, no storage
// - status read never advances read pointer
// - clock select divides by one or four
// - threshold access bit opens threshold registers
// - xon any bit enables xon any
// - loopback routes serial and modem bits
// - irq enable drives irq pins, output
// - fifo ready enable, loopback status bit
// - request bit drives request output
// - terminal ready bit drives its output
// - upper control bits need feature enable
module ulsmc_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // host port
  input wire logic host_cs_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [2:0] host_addr_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  // received characters
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_break_flag_i,
  input wire logic rx_framing_flag_i,
  input wire logic rx_parity_flag_i,
  output logic rx_ready_o,
  // transmitter state and feature enable
  input wire logic thr_empty_i,
  input wire logic tsr_empty_i,
  input wire logic efr_wr_en_i,
  // serial path
  input wire logic tx_serial_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic rx_serial_o,
  // modem lines
  input wire logic [3:0] modem_in_i,
  output logic [3:0] modem_status_hi_o,
  input wire logic auto_rts_en_i,
  input wire logic auto_rts_assert_i,
  output logic request_send_out_n_o,
  output logic terminal_ready_out_n_o,
  // interrupt and general output pins
  input wire logic irq_a_i,
  input wire logic irq_b_i,
  output logic irq_line_a_o,
  output logic irq_line_b_o,
  output logic irq_line_oe_o,
  output logic general_output_pin_o,
  // settings to the rest of the channel
  output logic xon_any_en_o,
  output logic thresh_access_o,
  output logic fifo_rdy_en_o,
  output logic baud_tick_o
);
  ulsmc_pkg::ulsmc_state_t st_q, st_d;
  ulsmc_pkg::ulsmc_rx_entry_t in_ent, top_ent;
  logic rd_lsr, rd_rhr, rd_mcr, wr_mcr, wr_lsr;
  logic fifo_in_rdy, fifo_out_vld;
  logic push, pop, in_err, top_err;
  logic [7:0] lsr_val;
  logic [7:0] m;
  logic loop;

  function automatic logic hit(input logic cs, input logic [2:0] a,
                               input logic [2:0] r);
    return cs && (a == r);
  endfunction : hit

  function automatic logic any_err(
    input ulsmc_pkg::ulsmc_rx_entry_t e);
    return e.brk || e.fe || e.pe;
  endfunction : any_err

  assign rd_lsr = host_rd_i && hit(host_cs_i, host_addr_i,
                                   `ULSMC_ADDR_LSR);
  assign rd_rhr = host_rd_i && hit(host_cs_i, host_addr_i,
                                   `ULSMC_ADDR_RHR);
  assign rd_mcr = host_rd_i && hit(host_cs_i, host_addr_i,
                                   `ULSMC_ADDR_MCR);
  assign wr_mcr = host_wr_i && hit(host_cs_i, host_addr_i,
                                   `ULSMC_ADDR_MCR);
  assign wr_lsr = host_wr_i && hit(host_cs_i, host_addr_i,
                                   `ULSMC_ADDR_LSR);

  always_comb begin
    in_ent.brk = rx_break_flag_i;
    in_ent.fe = rx_framing_flag_i;
    in_ent.pe = rx_parity_flag_i;
    // a break character carries no data
    in_ent.data = rx_break_flag_i ? 8'h00 : rx_data_i;
  end

  assign push = rx_valid_i && fifo_in_rdy;
  // only a holding read pops; a status read has no path here
  assign pop = rd_rhr && fifo_out_vld;
  assign in_err = push && any_err(in_ent);
  assign top_err = pop && any_err(top_ent);

  ulsmc_fifo #(
    .W($bits(ulsmc_pkg::ulsmc_rx_entry_t)),
    .DEPTH(`ULSMC_FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(rx_valid_i),
    .in_data_i(in_ent),
    .in_ready_o(fifo_in_rdy),
    .out_valid_o(fifo_out_vld),
    .out_data_o(top_ent),
    .out_ready_i(rd_rhr)
  );

  ulsmc_presc u_presc (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .div4_i(st_q.modem_control[`ULSMC_MCR_CLK]),
    .tick_o(baud_tick_o)
  );

  always_comb begin
    lsr_val = 8'h00;
    lsr_val[`ULSMC_LSR_FERR] = (st_q.err_cnt != 4'h0);
    lsr_val[`ULSMC_LSR_TEMT] = thr_empty_i && tsr_empty_i;
    lsr_val[`ULSMC_LSR_THRE] = thr_empty_i;
    // top entry flags go straight to the bus, nothing is latched
    lsr_val[`ULSMC_LSR_BI] = fifo_out_vld && top_ent.brk;
    lsr_val[`ULSMC_LSR_FE] = fifo_out_vld && top_ent.fe;
    lsr_val[`ULSMC_LSR_PE] = fifo_out_vld && top_ent.pe;
    lsr_val[`ULSMC_LSR_OE] = st_q.ovr;
    lsr_val[`ULSMC_LSR_DR] = fifo_out_vld;
  end

  always_comb begin
    st_d = st_q;
    // count of flagged entries held in the fifo
    unique case ({in_err, top_err})
      2'b10: st_d.err_cnt = st_q.err_cnt + 4'h1;
      2'b01: st_d.err_cnt = st_q.err_cnt - 4'h1;
      default: st_d.err_cnt = st_q.err_cnt;
    endcase
    // clear on status read, a loss in the same cycle still wins
    if (rd_lsr) begin
      st_d.ovr = 1'b0;
    end
    if (rx_valid_i && !fifo_in_rdy) begin
      st_d.ovr = 1'b1;
    end
    // status address takes no write at all
    if (wr_mcr && !wr_lsr) begin
      st_d.modem_control[4:0] = host_data_bus_i[4:0];
      if (efr_wr_en_i) begin
        st_d.modem_control[7:5] = host_data_bus_i[7:5];
      end
    end
    if (rd_lsr) begin
      st_d.rdata = lsr_val;
    end else if (rd_rhr) begin
      st_d.rdata = fifo_out_vld ? top_ent.data : 8'h00;
    end else if (rd_mcr) begin
      st_d.rdata = st_q.modem_control;
    end
    m = st_d.modem_control;
    loop = m[`ULSMC_MCR_LOOP];
    // loopback keeps the line idle so the far end sees nothing
    st_d.ser_out = loop ? 1'b1 : tx_serial_i;
    st_d.ser_in = loop ? tx_serial_i : serial_in_i;
    st_d.msr_hi = loop ? {m[`ULSMC_MCR_IRQ], m[`ULSMC_MCR_RDY],
                          m[`ULSMC_MCR_DTR], m[`ULSMC_MCR_RTS]}
                       : modem_in_i;
    if (loop) begin
      st_d.rts_n = 1'b1;
    end else if (auto_rts_en_i) begin
      st_d.rts_n = !auto_rts_assert_i;
    end else begin
      st_d.rts_n = !m[`ULSMC_MCR_RTS];
    end
    st_d.dtr_n = loop ? 1'b1 : !m[`ULSMC_MCR_DTR];
    st_d.irq_a = irq_a_i;
    st_d.irq_b = irq_b_i;
    st_d.irq_oe = m[`ULSMC_MCR_IRQ];
    st_d.gop = !m[`ULSMC_MCR_IRQ];
    st_d.xon_any = m[`ULSMC_MCR_XANY];
    st_d.thr_acc = m[`ULSMC_MCR_TACC];
    st_d.rdy_en = m[`ULSMC_MCR_RDY];
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '{default: '0, modem_control: `ULSMC_MCR_RST, ser_out: 1'b1,
                ser_in: 1'b1, rts_n: 1'b1, dtr_n: 1'b1, gop: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign host_data_bus_o = st_q.rdata;
  assign rx_ready_o = fifo_in_rdy;
  assign serial_out_o = st_q.ser_out;
  assign rx_serial_o = st_q.ser_in;
  assign modem_status_hi_o = st_q.msr_hi;
  assign request_send_out_n_o = st_q.rts_n;
  assign terminal_ready_out_n_o = st_q.dtr_n;
  assign irq_line_a_o = st_q.irq_a;
  assign irq_line_b_o = st_q.irq_b;
  assign irq_line_oe_o = st_q.irq_oe;
  assign general_output_pin_o = st_q.gop;
  assign xon_any_en_o = st_q.xon_any;
  assign thresh_access_o = st_q.thr_acc;
  assign fifo_rdy_en_o = st_q.rdy_en;

  // checks

  sequence mcr_write(logic [7:0] v);
    wr_mcr && efr_wr_en_i && host_data_bus_i == v;
  endsequence

  sequence loop_on;
    wr_mcr && host_data_bus_i[`ULSMC_MCR_LOOP];
  endsequence

  ferr_set_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (in_err && !top_err) ##1 rd_lsr |=>
      host_data_bus_o[`ULSMC_LSR_FERR])
    else $error("fifo error bit missed a flagged entry");

  ferr_clr_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (!fifo_out_vld && rd_lsr) |=> !host_data_bus_o[`ULSMC_LSR_FERR])
    else $error("fifo error bit set with empty fifo");

  temt_bit_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    rd_lsr |=> host_data_bus_o[`ULSMC_LSR_TEMT] ==
      ($past(thr_empty_i) && $past(tsr_empty_i)))
    else $error("transmit empty bit wrong");

  thre_bit_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    rd_lsr |=> host_data_bus_o[`ULSMC_LSR_THRE] ==
      $past(thr_empty_i))
    else $error("holding empty bit wrong");

  brk_zero_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_rhr && fifo_out_vld && top_ent.brk) |=>
      host_data_bus_o == 8'h00)
    else $error("break character not zero");

  top_flags_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_lsr && fifo_out_vld) |=>
      host_data_bus_o[`ULSMC_LSR_BI:`ULSMC_LSR_PE] ==
      $past({top_ent.brk, top_ent.fe, top_ent.pe}))
    else $error("top entry flags not shown");

  fe_bit_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_lsr && fifo_out_vld && !top_ent.fe) |=>
      !host_data_bus_o[`ULSMC_LSR_FE])
    else $error("framing bit set without cause");

  pe_bit_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_lsr && fifo_out_vld && top_ent.pe) |=>
      host_data_bus_o[`ULSMC_LSR_PE])
    else $error("parity bit missing");

  ovr_set_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rx_valid_i && !rx_ready_o) ##1 rd_lsr |=>
      host_data_bus_o[`ULSMC_LSR_OE])
    else $error("overrun not reported");

  dr_bit_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    rd_lsr |=> host_data_bus_o[`ULSMC_LSR_DR] == $past(fifo_out_vld))
    else $error("data ready bit wrong");

  lsr_nopop_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (rd_lsr && fifo_out_vld && !rx_valid_i) |=> fifo_out_vld &&
      top_ent == $past(top_ent))
    else $error("status read moved the fifo");

  tacc_xany_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (wr_mcr && efr_wr_en_i) |=>
      thresh_access_o == $past(host_data_bus_i[`ULSMC_MCR_TACC]) &&
      xon_any_en_o == $past(host_data_bus_i[`ULSMC_MCR_XANY]))
    else $error("upper control bits not applied");

  lock_upper_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (wr_mcr && !efr_wr_en_i) |=> st_q.modem_control[7:5] == $past(st_q.modem_control[7:5]))
    else $error("upper control bits changed while locked");

  lsr_ro_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (wr_lsr && !rd_lsr) |=> $stable(st_q.modem_control))
    else $error("status write changed a register");

  loop_idle_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    loop_on ##1 !wr_mcr |-> serial_out_o)
    else $error("serial out not idle in loopback");

  loop_msr_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    loop_on |=> modem_status_hi_o ==
      $past({host_data_bus_i[`ULSMC_MCR_IRQ],
             host_data_bus_i[`ULSMC_MCR_RDY],
             host_data_bus_i[`ULSMC_MCR_DTR],
             host_data_bus_i[`ULSMC_MCR_RTS]}) &&
      request_send_out_n_o && terminal_ready_out_n_o)
    else $error("loopback modem bits wrong");

  irq_en_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (wr_mcr && host_data_bus_i[`ULSMC_MCR_IRQ]) |=>
      irq_line_oe_o && !general_output_pin_o)
    else $error("irq enable not applied");

  rts_drive_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (wr_mcr && !auto_rts_en_i && host_data_bus_i[`ULSMC_MCR_RTS] &&
     !host_data_bus_i[`ULSMC_MCR_LOOP]) |=> !request_send_out_n_o)
    else $error("request output not asserted");

  dtr_drive_a: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    mcr_write(8'h00) |=> terminal_ready_out_n_o && fifo_rdy_en_o == 1'b0)
    else $error("terminal ready output wrong");
endmodule : ulsmc_top

// ### bench/ulsmc_modem_model.sv
`timescale 1ns/1ps
module ulsmc_modem_model (
  // clock
  input wire logic ref_clk_i,
  // receive character path
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic [2:0] rx_flags_o,
  // line side
  output logic serial_o,
  output logic [3:0] modem_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_flags_o = 3'h0;
    serial_o = 1'b1;
    modem_o = 4'h0;
  end
  // flags are break, framing, parity; drop offers for one cycle only
  task automatic send(input logic [7:0] d, input logic [2:0] f,
                      input logic drop);
    int n;
    logic ok;
    @(posedge ref_clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_data_o = d;
    rx_flags_o = f;
    n = 0;
    // ready is read while settled, i.e. the value the next edge samples
    do begin
      ok = (rx_ready_i === 1'b1);
      @(posedge ref_clk_i);
      n++;
    end while (!drop && !ok && n < 64);
    #1;
    rx_valid_o = 1'b0;
    // released lines show junk so a stale char is never taken
    rx_data_o = ~d;
    rx_flags_o = ~f;
  endtask : send
  task automatic set_lines(input logic s, input logic [3:0] m);
    @(posedge ref_clk_i);
    #1;
    serial_o = s;
    modem_o = m;
  endtask : set_lines
endmodule : ulsmc_modem_model

// ### bench/ulsmc_top_test.sv
`timescale 1ns/1ps
`include "ulsmc_consts.svh"
module ulsmc_top_test;
  logic clk, srst, cs, rd, wr, thr_e, tsr_e, enhanced_feature_reg, tx_s, a_en, a_as;
  logic ia, ib, rdy, vld, s_in, s_out, rx_s, rts_n, dtr_n, la, lb, oe;
  logic gop, xon, tacc, fen, tick;
  logic [2:0] addr, fl;
  logic [3:0] m_in, modem_status_reg;
  logic [7:0] wd, rdat, rxd, v;
  int err_count, comparisons, cycles;

  ulsmc_top u_ulsmc_top (.ref_clk_i(clk), .srst_i(srst), .host_cs_i(cs),
    .host_rd_i(rd), .host_wr_i(wr), .host_addr_i(addr),
    .host_data_bus_i(wd), .host_data_bus_o(rdat), .rx_valid_i(vld),
    .rx_data_i(rxd), .rx_break_flag_i(fl[2]), .rx_framing_flag_i(fl[1]),
    .rx_parity_flag_i(fl[0]), .rx_ready_o(rdy), .thr_empty_i(thr_e),
    .tsr_empty_i(tsr_e), .efr_wr_en_i(enhanced_feature_reg), .tx_serial_i(tx_s),
    .serial_in_i(s_in), .serial_out_o(s_out), .rx_serial_o(rx_s),
    .modem_in_i(m_in), .modem_status_hi_o(modem_status_reg), .auto_rts_en_i(a_en),
    .auto_rts_assert_i(a_as), .request_send_out_n_o(rts_n),
    .terminal_ready_out_n_o(dtr_n), .irq_a_i(ia), .irq_b_i(ib),
    .irq_line_a_o(la), .irq_line_b_o(lb), .irq_line_oe_o(oe),
    .general_output_pin_o(gop), .xon_any_en_o(xon),
    .thresh_access_o(tacc), .fifo_rdy_en_o(fen), .baud_tick_o(tick));

  ulsmc_modem_model u_ulsmc_modem_model (.ref_clk_i(clk), .rx_ready_i(rdy),
    .rx_valid_o(vld), .rx_data_o(rxd), .rx_flags_o(fl), .serial_o(s_in),
    .modem_o(m_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // hangs are cut well past the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cs = 1'b1;
    wr = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
    cs = 1'b0;
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] r);
    @(posedge clk);
    #1;
    cs = 1'b1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    cs = 1'b0;
    rd = 1'b0;
    wait_cyc(1);
    r = rdat;
  endtask : rd_reg

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    rd_reg(a, v);
    chk(v, exp);
  endtask : chk_reg

  task automatic t_reset;
    chk_reg(`ULSMC_ADDR_LSR, 8'h60);
    chk_reg(`ULSMC_ADDR_MCR, `ULSMC_MCR_RST);
    chk({4'h0, dtr_n, rts_n, oe, gop}, 8'h0D);
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx_empty;
    for (int j = 0; j < 4; j++) begin
      thr_e = j[1];
      tsr_e = j[0];
      chk_reg(`ULSMC_ADDR_LSR, {1'b0, j[1] & j[0], j[1], 5'h0});
      chk_reg(`ULSMC_ADDR_LSR, {1'b0, j[1] & j[0], j[1], 5'h0});
    end
    thr_e = 1'b1;
    tsr_e = 1'b1;
    $display("test transmitter empty done");
  endtask : t_tx_empty

  task automatic t_rx_flags;
    logic [7:0] ch [4] = '{8'h11, 8'h22, 8'h33, 8'h5A};
    logic [2:0] f [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [7:0] el [4] = '{8'hE1, 8'hE5, 8'hE9, 8'hF1};
    logic [7:0] er [4] = '{8'h11, 8'h22, 8'h33, 8'h00};
    for (int i = 0; i < 4; i++) begin
      u_ulsmc_modem_model.send(ch[i], f[i], 1'b0);
    end
    // status before holding read pairs flags with their char
    for (int i = 0; i < 4; i++) begin
      chk_reg(`ULSMC_ADDR_LSR, el[i]);
      chk_reg(`ULSMC_ADDR_LSR, el[i]);
      chk_reg(`ULSMC_ADDR_RHR, er[i]);
    end
    chk_reg(`ULSMC_ADDR_LSR, 8'h60);
    $display("test receive flags done");
  endtask : t_rx_flags

  task automatic t_overrun;
    for (int i = 0; i < 8; i++) begin
      u_ulsmc_modem_model.send(8'h80 + 8'(i), 3'h0, 1'b0);
    end
    chk({7'h0, rdy}, 8'h00);
    u_ulsmc_modem_model.send(8'hEE, 3'h0, 1'b1);
    chk_reg(`ULSMC_ADDR_LSR, 8'h63);
    chk_reg(`ULSMC_ADDR_LSR, 8'h61);
    wr_reg(`ULSMC_ADDR_LSR, 8'hFF);
    chk_reg(`ULSMC_ADDR_LSR, 8'h61);
    for (int i = 0; i < 8; i++) begin
      chk_reg(`ULSMC_ADDR_RHR, 8'h80 + 8'(i));
    end
    chk_reg(`ULSMC_ADDR_LSR, 8'h60);
    chk_reg(`ULSMC_ADDR_RHR, 8'h00);
    chk({7'h0, rdy}, 8'h01);
    $display("test overrun done");
  endtask : t_overrun

  task automatic count_ticks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    wait_cyc(2);
    repeat (8) begin
      @(posedge clk);
      #1;
      n = n + 8'(tick);
    end
    chk(n, exp);
  endtask : count_ticks

  task automatic t_mcr;
    enhanced_feature_reg = 1'b0;
    wr_reg(`ULSMC_ADDR_MCR, 8'hEB);
    chk_reg(`ULSMC_ADDR_MCR, 8'h0B);
    chk({4'h0, dtr_n, rts_n, oe, gop}, 8'h02);
    chk({5'h0, xon, tacc, fen}, 8'h00);
    enhanced_feature_reg = 1'b1;
    wr_reg(`ULSMC_ADDR_MCR, 8'hE4);
    chk_reg(`ULSMC_ADDR_MCR, 8'hE4);
    chk({4'h0, dtr_n, rts_n, oe, gop}, 8'h0D);
    chk({5'h0, xon, tacc, fen}, 8'h07);
    count_ticks(8'h02);
    wr_reg(`ULSMC_ADDR_MCR, 8'h0A);
    count_ticks(8'h08);
    a_en = 1'b1;
    a_as = 1'b1;
    ia = 1'b1;
    wait_cyc(3);
    chk({5'h0, rts_n, oe, la}, 8'h03);
    a_as = 1'b0;
    ia = 1'b0;
    ib = 1'b1;
    wait_cyc(3);
    chk({4'h0, rts_n, oe, la, lb}, 8'h0D);
    a_en = 1'b0;
    $display("test modem control done");
  endtask : t_mcr

  task automatic t_loop;
    u_ulsmc_modem_model.set_lines(1'b0, 4'h6);
    tx_s = 1'b0;
    wr_reg(`ULSMC_ADDR_MCR, 8'h1B);
    wait_cyc(3);
    chk({modem_status_reg, 1'b0, s_out, rx_s, 1'b0}, 8'hB4);
    chk({6'h0, rts_n, dtr_n}, 8'h03);
    tx_s = 1'b1;
    wait_cyc(3);
    chk({7'h0, rx_s}, 8'h01);
    wr_reg(`ULSMC_ADDR_MCR, 8'h14);
    wait_cyc(3);
    chk({4'h0, modem_status_reg}, 8'h04);
    tx_s = 1'b0;
    wr_reg(`ULSMC_ADDR_MCR, 8'h00);
    wait_cyc(3);
    chk({modem_status_reg, 2'h0, s_out, rx_s}, 8'h60);
    $display("test loopback done");
  endtask : t_loop

  initial begin
    {cs, rd, wr, a_en, a_as, ia, ib, tx_s, enhanced_feature_reg} = 9'h000;
    {thr_e, tsr_e, srst} = 3'h7;
    addr = 3'h0;
    wd = 8'h00;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_tx_empty();
    t_rx_flags();
    t_overrun();
    t_mcr();
    t_loop();
    end_of_test();
  end
endmodule : ulsmc_top_test
